// file: design/gp_event_enable_and_input.sv
// Purpose: Event enable, event status and input level registers with event output
// Assumes: Host reaches these registers through configuration function 0 only
// Notes: Socket power and twelve-volt events arrive as one-cycle strobes, video-port enables as levels, from logic on sys_clk
`timescale 1ns/100ps
`include "gp_event_map.svh"

// Operation
// - Sixteen-bit event enable register at AAh gates sources onto the event output.
// - Event output stays asserted until the status bit or its enable bit is cleared.
// - Event reaches a pin only on a terminal configured for event signalling.
// - Bit 15 enables events on socket 0 video-port enable change.
// - Bit 14 enables events on socket 1 video-port enable change.
// - Bit 11 enables events on any socket power state change.
// - Bit 8 enables events on twelve-volt programming request changes.
// - Bits 4..0 enable events on input changes of terminals 5,4,2,1,0.
// - Enable bits 13-12, 10-9, 7-5 read zero; all enables reset zero.
// - Read-only sixteen-bit input register at ACh shows input terminal levels.
// - Input bits 4..0 show synchronised levels of terminals 5,4,2,1,0.
// - Input register bits 15..5 read zero.
// - Writes to the input register are ignored.
// - Writing one clears a status bit and its pending event.
// - Status bits latch regardless of enables.
module gp_event_enable_and_input
    import gp_event_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic cfg_func0,
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [7:0] cfg_addr,
    input wire logic [1:0] cfg_byte_en,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic video_port_enable_setting_0,
    input wire logic video_port_enable_setting_1,
    input wire logic socket_power_changed,
    input wire logic twelve_volt_changed,
    input wire logic [4:0] input_pins,
    input wire logic [13:0] terminal_function,
    output logic [6:0] multifunction_terminals_out,
    output logic [6:0] multifunction_terminals_oe_n,
    output logic system_event_output
);

    reg16_t event_enable_mask_r;
    reg16_t event_enable_mask_nxt;
    reg16_t event_status_r;
    reg16_t event_status_nxt;
    reg16_t cfg_rdata_r;
    reg16_t cfg_rdata_nxt;
    logic cfg_rvalid_r;
    logic cfg_rvalid_nxt;
    logic video0_prev_r;
    logic video0_prev_nxt;
    logic video1_prev_r;
    logic video1_prev_nxt;
    logic event_r;
    logic event_nxt;
    logic [6:0] term_out_r;
    logic [6:0] term_out_nxt;
    logic [6:0] term_oe_n_r;
    logic [6:0] term_oe_n_nxt;
    reg16_t event_set;
    reg16_t write_mask;
    inputs_t input_is_general;
    logic wr_enable;
    logic wr_status;

    pin_sync_if sync_bus ();

    pin_input_sync u_pin_input_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .pins(input_pins),
        .sync(sync_bus.source)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic term_function_t term_fn(input logic [13:0] cfg, input int idx);
        term_fn = term_function_t'(cfg[2*idx +: 2]);
    endfunction : term_fn

    function automatic reg16_t lane_mask(input logic [1:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // Input bit order maps to terminals 5,4,2,1,0
    always_comb begin
        input_is_general[4] = term_fn(terminal_function, 5) == TERM_GENERAL_INPUT;
        input_is_general[3] = term_fn(terminal_function, 4) == TERM_GENERAL_INPUT;
        input_is_general[2] = term_fn(terminal_function, 2) == TERM_GENERAL_INPUT;
        input_is_general[1] = term_fn(terminal_function, 1) == TERM_GENERAL_INPUT;
        input_is_general[0] = term_fn(terminal_function, 0) == TERM_GENERAL_INPUT;
    end

    // ----------------------------------------
    // Register writes and event capture
    // ----------------------------------------
    always_comb begin
        write_mask = lane_mask(cfg_byte_en) & cfg_wdata;
        // Function 1 accesses fall through to nothing here
        wr_enable = cfg_write && cfg_func0 && (cfg_addr == `EVT_ENABLE_OFFSET);
        wr_status = cfg_write && cfg_func0 && (cfg_addr == `EVT_STATUS_OFFSET);
        // Writes at INPUT_LEVELS_OFFSET decode to nothing and change nothing
        event_set = 16'h0000;
        event_set[`SOCKET0_VIDEO_BIT] = video_port_enable_setting_0 != video0_prev_r;
        event_set[`SOCKET1_VIDEO_BIT] = video_port_enable_setting_1 != video1_prev_r;
        event_set[`POWER_CHANGE_BIT] = socket_power_changed;
        event_set[`TWELVE_VOLT_BIT] = twelve_volt_changed;
        event_set[4:0] = sync_bus.changed & input_is_general;
        video0_prev_nxt = video_port_enable_setting_0;
        video1_prev_nxt = video_port_enable_setting_1;
        event_enable_mask_nxt = event_enable_mask_r;
        if (wr_enable) begin
            event_enable_mask_nxt = ((event_enable_mask_r & ~lane_mask(cfg_byte_en))
                | write_mask) & `EVT_WRITABLE_MASK;
        end
        event_status_nxt = event_status_r;
        if (wr_status) begin
            event_status_nxt = event_status_r & ~write_mask;
        end
        // Set wins over a clear in the same cycle; enables play no part here
        event_status_nxt = (event_status_nxt | event_set) & `EVT_WRITABLE_MASK;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        cfg_rvalid_nxt = cfg_read && cfg_func0;
        cfg_rdata_nxt = 16'h0000;
        if (cfg_read && cfg_func0) begin
            unique case (cfg_addr)
                `EVT_ENABLE_OFFSET: cfg_rdata_nxt = event_enable_mask_r;
                `EVT_STATUS_OFFSET: cfg_rdata_nxt = event_status_r;
                `INPUT_LEVELS_OFFSET: cfg_rdata_nxt = {11'h000, sync_bus.level};
                default: cfg_rdata_nxt = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // Event output and terminal drive
    // ----------------------------------------
    // Held while any enabled status bit stays set, so only a status or enable clear drops it
    always_comb begin
        event_nxt = |(event_status_r & event_enable_mask_r);
        term_out_nxt = 7'h00;
        term_oe_n_nxt = 7'h7F;
        for (int t = 0; t < `TERMINAL_COUNT; t++) begin
            if (term_fn(terminal_function, t) == TERM_EVENT_OUTPUT) begin
                // Event line is active low, driven only on configured terminals
                term_out_nxt[t] = ~event_nxt;
                term_oe_n_nxt[t] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            event_enable_mask_r <= `EVT_ENABLE_RESET;
            event_status_r <= `EVT_STATUS_RESET;
            cfg_rdata_r <= 16'h0000;
            cfg_rvalid_r <= 1'b0;
            video0_prev_r <= 1'b0;
            video1_prev_r <= 1'b0;
            event_r <= 1'b0;
            term_out_r <= 7'h00;
            term_oe_n_r <= 7'h7F;
        end else if (clk_en) begin
            event_enable_mask_r <= event_enable_mask_nxt;
            event_status_r <= event_status_nxt;
            cfg_rdata_r <= cfg_rdata_nxt;
            cfg_rvalid_r <= cfg_rvalid_nxt;
            video0_prev_r <= video0_prev_nxt;
            video1_prev_r <= video1_prev_nxt;
            event_r <= event_nxt;
            term_out_r <= term_out_nxt;
            term_oe_n_r <= term_oe_n_nxt;
        end
    end

    assign cfg_rdata = cfg_rdata_r;
    assign cfg_rvalid = cfg_rvalid_r;
    assign system_event_output = event_r;
    assign multifunction_terminals_out = term_out_r;
    assign multifunction_terminals_oe_n = term_oe_n_r;

endmodule : gp_event_enable_and_input

// file: design/gp_event_map.svh
// Purpose: Offsets, field positions, reset values and masks for the event unit
// Assumes: Configuration offsets are byte addresses within function 0
// Notes: Definitions only
`ifndef GP_EVENT_MAP_SVH
`define GP_EVENT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EVT_STATUS_OFFSET 8'hA8
`define EVT_ENABLE_OFFSET 8'hAA
`define INPUT_LEVELS_OFFSET 8'hAC

// ----------------------------------------
// Enable field positions
// ----------------------------------------
`define SOCKET0_VIDEO_BIT 15
`define SOCKET1_VIDEO_BIT 14
`define POWER_CHANGE_BIT 11
`define TWELVE_VOLT_BIT 8

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define EVT_WRITABLE_MASK 16'hC91F
`define EVT_ENABLE_RESET 16'h0000
`define EVT_STATUS_RESET 16'h0000
`define INPUT_LEVELS_MASK 16'h001F
`define INPUT_COUNT 5
`define TERMINAL_COUNT 7

`endif

// file: design/gp_event_pkg.sv
// Purpose: Types shared by the event unit modules
// Assumes: None
// Notes: Constants live in gp_event_map.svh
package gp_event_pkg;

    typedef logic [15:0] reg16_t;
    typedef logic [4:0] inputs_t;

    // ----------------------------------------
    // Multifunction terminal function codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        TERM_GENERAL_INPUT,
        TERM_GENERAL_OUTPUT,
        TERM_EVENT_OUTPUT,
        TERM_OTHER
    } term_function_t;

endpackage : gp_event_pkg

// file: design/pin_sync_if.sv
// Purpose: Carries synchronised input levels and change strobes between modules
// Assumes: Single clock domain
// Notes: Source is the synchroniser, sink is the event unit
`timescale 1ns/100ps
interface pin_sync_if;
    import gp_event_pkg::*;

    inputs_t level;
    inputs_t changed;

    modport source (output level, output changed);
    modport sink (input level, input changed);

endinterface : pin_sync_if

// file: design/pin_input_sync.sv
// Purpose: Three-flop synchroniser and change detector for the general inputs
// Assumes: Pins are asynchronous to sys_clk
// Notes: A change counts once the second and third stages agree
`timescale 1ns/100ps
`include "gp_event_map.svh"
module pin_input_sync
    import gp_event_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [4:0] pins,
    pin_sync_if.source sync
);

    inputs_t stage1_r;
    inputs_t stage1_nxt;
    inputs_t stage2_r;
    inputs_t stage2_nxt;
    inputs_t stage3_r;
    inputs_t stage3_nxt;
    inputs_t level_r;
    inputs_t level_nxt;
    inputs_t changed_r;
    inputs_t changed_nxt;
    logic primed_r;
    logic primed_nxt;
    logic [1:0] fill_r;
    logic [1:0] fill_nxt;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // First stage feeds only the second stage
    always_comb begin
        stage1_nxt = pins;
        stage2_nxt = stage1_r;
        stage3_nxt = stage2_r;
        level_nxt = level_r;
        changed_nxt = 5'h00;
        primed_nxt = primed_r;
        fill_nxt = (fill_r == 2'h3) ? fill_r : fill_r + 2'h1;
        for (int i = 0; i < `INPUT_COUNT; i++) begin
            if (stage2_r[i] == stage3_r[i]) begin
                level_nxt[i] = stage3_r[i];
                // No change reported until the pipeline holds real pin values
                changed_nxt[i] = primed_r && (stage3_r[i] != level_r[i]);
            end
        end
        // Third stage holds real pin values only after three edges
        if (!primed_r) begin
            level_nxt = stage3_r;
            primed_nxt = fill_r == 2'h3;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage1_r <= 5'h00;
            stage2_r <= 5'h00;
            stage3_r <= 5'h00;
            level_r <= 5'h00;
            changed_r <= 5'h00;
            primed_r <= 1'b0;
            fill_r <= 2'h0;
        end else if (clk_en) begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
            stage3_r <= stage3_nxt;
            level_r <= level_nxt;
            changed_r <= changed_nxt;
            primed_r <= primed_nxt;
            fill_r <= fill_nxt;
        end
    end

    assign sync.level = level_r;
    assign sync.changed = changed_r;

endmodule : pin_input_sync

// file: tb/gp_event_enable_and_input_props.sv
// Purpose: Port checks for the event unit
// Assumes: clk_en held high
// Notes: Bound from the bench top
`timescale 1ns/100ps
module gp_event_enable_and_input_props (
    input logic sys_clk,
    input logic reset,
    input logic clk_en,
    input logic cfg_func0,
    input logic cfg_write,
    input logic cfg_read,
    input logic [7:0] cfg_addr,
    input logic [15:0] cfg_rdata,
    input logic cfg_rvalid,
    input logic [13:0] terminal_function,
    input logic [6:0] multifunction_terminals_out,
    input logic [6:0] multifunction_terminals_oe_n,
    input logic system_event_output
);
    logic [6:0] oe_exp;
    always_comb begin
        for (int t = 0; t < 7; t++) begin
            oe_exp[t] = terminal_function[2*t +: 2] != 2'h2;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rv; cfg_read && cfg_func0 && clk_en |=> cfg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_nrv; clk_en && !(cfg_read && cfg_func0) |=> !cfg_rvalid; endproperty
    a_nrv: assert property (p_nrv) else $error("answer without request");
    property p_rz; !cfg_rvalid |-> cfg_rdata == 16'h0000; endproperty
    a_rz: assert property (p_rz) else $error("read data outside answer");
    property p_rin; cfg_rvalid && $past(cfg_addr) == 8'hAC |-> cfg_rdata[15:5] == 11'h000; endproperty
    a_rin: assert property (p_rin) else $error("input reserved bits set");
    property p_ren; cfg_rvalid && $past(cfg_addr) == 8'hAA |-> (cfg_rdata & 16'h36E0) == 16'h0000; endproperty
    a_ren: assert property (p_ren) else $error("enable reserved bits set");
    property p_oe; !$past(reset) |-> multifunction_terminals_oe_n == $past(oe_exp); endproperty
    a_oe: assert property (p_oe) else $error("pin drive not as configured");
    property p_out;
        multifunction_terminals_out == ({7{~system_event_output}} & ~multifunction_terminals_oe_n);
    endproperty
    a_out: assert property (p_out) else $error("event pin level wrong");
    // Event output lags a write by two edges
    property p_hold;
        system_event_output && clk_en && !cfg_write && !$past(cfg_write) |=> system_event_output;
    endproperty
    a_hold: assert property (p_hold) else $error("event dropped uncleared");
endmodule : gp_event_enable_and_input_props

// file: tb/gp_host_model.sv
// Purpose: Host software issuing configuration accesses
// Assumes: Requests launch at a rising edge
// Notes: Function 1 writes only prove they are ignored
`timescale 1ns/100ps
module gp_host_model (
    input logic sys_clk,
    input logic [15:0] cfg_rdata,
    input logic cfg_rvalid,
    output logic cfg_func0 = 1'b1,
    output logic cfg_write = 1'b0,
    output logic cfg_read = 1'b0,
    output logic [7:0] cfg_addr = 8'h00,
    output logic [1:0] cfg_byte_en = 2'h3,
    output logic [15:0] cfg_wdata = 16'h0000
);
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic f0);
        @(posedge sys_clk);
        cfg_func0 <= f0;
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_write <= 1'b1;
        @(posedge sys_clk);
        cfg_write <= 1'b0;
        cfg_func0 <= 1'b1;
    endtask : wr
    task automatic wr_lane(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
        @(posedge sys_clk);
        cfg_byte_en <= b;
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_write <= 1'b1;
        @(posedge sys_clk);
        cfg_write <= 1'b0;
        cfg_byte_en <= 2'h3;
    endtask : wr_lane
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_read <= 1'b1;
        @(posedge sys_clk);
        cfg_read <= 1'b0;
        #1;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask : rd
endmodule : gp_host_model

// file: tb/tb_gp_event_enable_and_input.sv
// Purpose: Self-checking bench for the event unit
// Assumes: Terminal 6 carries the event, others are inputs
// Notes: Pins move only after the synchroniser settles
`timescale 1ns/100ps
module tb_gp_event_enable_and_input;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic v0 = 1'b0;
    logic v1 = 1'b0;
    logic pw = 1'b0;
    logic tv = 1'b0;
    logic [4:0] pins = 5'h00;
    logic func0, wr_s, rd_s, rvalid, evt;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata, rdata;
    logic [6:0] t_out, t_oe_n;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int srcs[9] = '{15, 14, 11, 8, 4, 3, 2, 1, 0};
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    gp_host_model host (.sys_clk(sys_clk), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .cfg_func0(func0),
        .cfg_write(wr_s), .cfg_read(rd_s), .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wdata));
    gp_event_enable_and_input dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .cfg_func0(func0),
        .cfg_write(wr_s), .cfg_read(rd_s), .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wdata),
        .cfg_rdata(rdata), .cfg_rvalid(rvalid), .video_port_enable_setting_0(v0),
        .video_port_enable_setting_1(v1), .socket_power_changed(pw), .twelve_volt_changed(tv),
        .input_pins(pins), .terminal_function(14'h2000), .multifunction_terminals_out(t_out),
        .multifunction_terminals_oe_n(t_oe_n), .system_event_output(evt));
    task automatic stop_test();
        $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        host.rd(a, d, v);
        chk("rvalid", 16'h0001, {15'h0000, v});
        chk("rdata", e, d);
    endtask : rdchk
    task automatic fire(input int k);
        @(posedge sys_clk);
        case (k)
            15: v0 <= ~v0;
            14: v1 <= ~v1;
            11: pw <= 1'b1;
            8: tv <= 1'b1;
            default: pins[k] <= ~pins[k];
        endcase
        @(posedge sys_clk);
        pw <= 1'b0;
        tv <= 1'b0;
    endtask : fire
    // Reset values, reserved bits, ignored writes, unmapped read
    task automatic t_regs();
        rdchk(8'hAA, 16'h0000);
        rdchk(8'hAC, 16'h0000);
        host.wr(8'hAA, 16'hFFFF, 1'b1);
        rdchk(8'hAA, 16'hC91F);
        host.wr(8'hAA, 16'h0000, 1'b0);
        rdchk(8'hAA, 16'hC91F);
        host.wr_lane(8'hAA, 16'h0000, 2'h2);
        rdchk(8'hAA, 16'h001F);
        @(posedge sys_clk) pins <= 5'h15;
        repeat (6) @(posedge sys_clk);
        host.wr(8'hAC, 16'hFFFF, 1'b1);
        rdchk(8'hAC, 16'h0015);
        rdchk(8'hA0, 16'h0000);
        host.wr(8'hAA, 16'h0000, 1'b1);
        host.wr(8'hA8, 16'hFFFF, 1'b1);
    endtask : t_regs
    // Latch while masked, then enable, then clear, for every source
    task automatic t_events();
        foreach (srcs[i]) begin
            fire(srcs[i]);
            repeat (8) @(posedge sys_clk);
            #1 chk("evt masked", 16'h0000, {15'h0000, evt});
            rdchk(8'hA8, 16'h0001 << srcs[i]);
            host.wr(8'hAA, 16'h0001 << srcs[i], 1'b1);
            repeat (2) @(posedge sys_clk);
            #1 chk("evt", 16'h0001, {15'h0000, evt});
            chk("oe_n", 16'h003F, {9'h000, t_oe_n});
            chk("t_out", 16'h0000, {9'h000, t_out});
            host.wr(8'hA8, 16'h0000, 1'b1);
            rdchk(8'hA8, 16'h0001 << srcs[i]);
            host.wr(8'hA8, 16'h0001 << srcs[i], 1'b1);
            repeat (2) @(posedge sys_clk);
            #1 chk("evt clear", 16'h0000, {15'h0000, evt});
            chk("t_out clear", 16'h0040, {9'h000, t_out});
            host.wr(8'hAA, 16'h0000, 1'b1);
        end
    endtask : t_events
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_events();
        stop_test();
    end
endmodule : tb_gp_event_enable_and_input
bind gp_event_enable_and_input gp_event_enable_and_input_props u_props (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .cfg_func0(cfg_func0), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .terminal_function(terminal_function),
    .multifunction_terminals_out(multifunction_terminals_out),
    .multifunction_terminals_oe_n(multifunction_terminals_oe_n), .system_event_output(system_event_output));
